// *** logic/pvil_params.svh ***
// Purpose: Offsets, field positions, reset values and vector layout of the interrupt logic
// Assumes: Included by bare name before use
// Notes: Definitions only
`ifndef PVIL_PARAMS_SVH
`define PVIL_PARAMS_SVH

`define PVIL_ADDR_STATUS 8'hDC
`define PVIL_ADDR_MASK 8'hDD
`define PVIL_ADDR_MODE 8'hDE
`define PVIL_ADDR_PRIO 8'hFF

`define PVIL_STATUS_RST 8'h00
`define PVIL_MASK_RST 8'h00
`define PVIL_PRIO_RST 8'h00
`define PVIL_GIE_RST 1'b0

`define PVIL_MODE_GIE 0
`define PVIL_PRIO_GRP_HI 7
`define PVIL_PRIO_GRP_MID 4
`define PVIL_PRIO_GRP_LO 1
`define PVIL_PRIO_C_SPLIT 5
`define PVIL_PRIO_C_SUB 6
`define PVIL_PRIO_A_SWAP 0

`define PVIL_VEC_BASE 8'h00
`define PVIL_VEC_PAGE 8'h00

`endif

// *** logic/pvil_pkg.sv ***
// Purpose: Types shared by the interrupt logic files
// Assumes: Nothing
// Notes: Eight levels, two sources per level
package pvil_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_PCL,
        ST_PUSH_PCH,
        ST_PUSH_FLG,
        ST_FETCH_HI,
        ST_FETCH_LO
    } pvil_state_e;

    typedef enum logic {
        OP_PUSH,
        OP_FETCH
    } pvil_op_e;

    typedef struct packed {
        pvil_op_e op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pvil_bus_s;

    typedef struct packed {
        pvil_state_e st;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] prio;
        logic gie;
        logic [1:0] hwp;
        logic [2:0] lvl;
        logic src;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] vhi;
        logic [7:0] rdata;
        logic ack;
        logic [2:0] ack_lvl;
        logic irq;
        logic bus_req;
        pvil_bus_s bus;
        logic jump;
        logic [15:0] jaddr;
    } pvil_regs_s;

endpackage

// *** logic/pvil_prio.sv ***
// Purpose: Picks the requesting level with the best programmed priority
// Assumes: Candidate vector already gated by enables and mask
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "pvil_params.svh"

module pvil_prio (
    input wire logic [7:0] cand_in,
    input wire logic [7:0] prio_in,
    output logic valid_out,
    output logic [2:0] level_out
);

    // Rank is group position then position inside the group; lower wins
    function automatic logic [3:0] level_rank(input logic [2:0] lvl, input logic [7:0] p);
        logic [2:0] code;
        logic [5:0] gpos;
        logic [1:0] g;
        logic [1:0] ipos;
        code = {p[`PVIL_PRIO_GRP_HI], p[`PVIL_PRIO_GRP_MID], p[`PVIL_PRIO_GRP_LO]};
        case (code)
            3'h1: gpos = {2'h1, 2'h0, 2'h2};
            3'h2: gpos = {2'h1, 2'h2, 2'h0};
            3'h3: gpos = {2'h2, 2'h0, 2'h1};
            3'h4: gpos = {2'h0, 2'h2, 2'h1};
            3'h5: gpos = {2'h0, 2'h1, 2'h2};
            default: gpos = {2'h2, 2'h1, 2'h0};
        endcase
        if (lvl < 3'h2) begin
            g = gpos[1:0];
            ipos = {1'b0, lvl[0] ^ p[`PVIL_PRIO_A_SWAP]};
        end else if (lvl < 3'h5) begin
            g = gpos[3:2];
            ipos = 2'(lvl - 3'h2);
        end else begin
            g = gpos[5:4];
            if (lvl == 3'h5) begin
                ipos = p[`PVIL_PRIO_C_SPLIT] ? 2'h2 : 2'h0;
            end else begin
                ipos = {1'b0, ~p[`PVIL_PRIO_C_SPLIT]}
                    + {1'b0, (lvl == 3'h7) ^ p[`PVIL_PRIO_C_SUB]};
            end
        end
        return {g, ipos};
    endfunction

    always_comb begin
        logic [3:0] best;
        best = 4'hF;
        valid_out = 1'b0;
        level_out = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (cand_in[i] && (!valid_out || level_rank(3'(i), prio_in) < best)) begin
                valid_out = 1'b1;
                level_out = 3'(i);
                best = level_rank(3'(i), prio_in);
            end
        end
    end

endmodule
`default_nettype wire

// *** logic/pvil_top.sv ***
// Purpose: Vectored interrupt logic with programmable level priority and vector sequencer
// Assumes: Core pulses instr_end_in at each instruction end; bus_done_in answers bus_req_out
// Notes: Level 0 flags are held here; other levels come as pending levels from the sources
// Notes on behaviour
// - The requesting level with the best programmed priority is served first.
// - Inside one level the source with the lower vector address wins, fixed.
// - Levels 0-1 form group A, 2-4 group B, 5-7 group C.
// - Priority bits 7,4,1 order groups; 001 gives B>C>A, 101 gives C>B>A.
// - Priority bit 5 orders group C; bit 6 orders levels 6 and 7.
// - Priority bit 0 chooses whether level 0 or level 1 wins.
// - Request status bit n reads 1 while level n has a request.
// - Request status is read-only, always readable, zero after reset.
// - With global enable off requests still show in status but are not vectored.
// - Hardware flags set on request, pulse the line, clear after acknowledge and service.
// - Level 0 timer source uses the hardware-cleared flag.
// - Flags of levels 1-7 stay set until software clears them at the source.
// - Service needs global enable, unmasked level, best priority and source enable.
// - Acceptance happens only at the end of an instruction.
// - Acceptance clears global enable, saves counter and flags, then vectors.
// - Push counter low, high, flags; fetch vector high, low; jump.
// - Vectors sit at even addresses inside 00H-FFH.
// - Return from interrupt sets global enable again.
// - After acknowledge the logic supplies the vector of the acknowledged source.
// - Mask bit n enables level n when 1.
// - Mode bit 0 is global enable, cleared by reset, set and cleared by instructions.
`timescale 1ns/1ps
`default_nettype none
`include "pvil_params.svh"

module pvil_top (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [15:0] src_req_in,
    input wire logic [15:0] src_en_in,
    input wire logic instr_end_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    input wire logic global_enable_instr_in,
    input wire logic global_disable_instr_in,
    input wire logic return_from_interrupt_in,
    output logic bus_req_out,
    output pvil_pkg::pvil_bus_s bus_out,
    input wire logic bus_done_in,
    input wire logic [7:0] bus_rdata_in,
    output logic ack_out,
    output logic [2:0] ack_level_out,
    output logic irq_pulse_out,
    output logic jump_out,
    output logic [15:0] jump_addr_out
);

    pvil_pkg::pvil_regs_s r;
    pvil_pkg::pvil_regs_s n;
    logic [15:0] req_vec;
    logic [7:0] lvl_req;
    logic [7:0] cand;
    logic win_valid;
    logic [2:0] win_lvl;
    logic win_src;
    logic accept;
    logic [1:0] hw_clr;

    // Vector slot: four bytes per level, two per source, always even
    function automatic logic [15:0] vec_addr(input logic [2:0] lvl, input logic src);
        logic [7:0] lo;
        lo = `PVIL_VEC_BASE + {3'h0, lvl, 2'h0} + {6'h0, src, 1'b0};
        return {`PVIL_VEC_PAGE, lo};
    endfunction

    // Level 0 uses the held flags, other levels the sources' own pending bits
    always_comb begin
        req_vec = {src_req_in[15:2], r.hwp} & src_en_in;
        for (int i = 0; i < 8; i++) begin
            lvl_req[i] = |req_vec[2*i +: 2];
        end
        cand = lvl_req & r.mask & {8{r.gie}};
    end

    pvil_prio u_prio (
        .cand_in(cand),
        .prio_in(r.prio),
        .valid_out(win_valid),
        .level_out(win_lvl)
    );

    assign win_src = ~req_vec[{win_lvl, 1'b0}];
    assign accept = (r.st == pvil_pkg::ST_IDLE) && win_valid && instr_end_in;

    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.jump = 1'b0;
        hw_clr = 2'h0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `PVIL_ADDR_MASK: n.mask = reg_wdata_in;
                `PVIL_ADDR_MODE: n.gie = reg_wdata_in[`PVIL_MODE_GIE];
                `PVIL_ADDR_PRIO: n.prio = reg_wdata_in;
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                `PVIL_ADDR_STATUS: n.rdata = r.status;
                `PVIL_ADDR_MASK: n.rdata = r.mask;
                `PVIL_ADDR_MODE: n.rdata = {7'h00, r.gie};
                `PVIL_ADDR_PRIO: n.rdata = r.prio;
                default: n.rdata = 8'h00;
            endcase
        end
        if (global_disable_instr_in) begin
            n.gie = 1'b0;
        end
        if (global_enable_instr_in || return_from_interrupt_in) begin
            n.gie = 1'b1;
        end
        unique case (r.st)
            pvil_pkg::ST_IDLE: begin
                if (accept) begin
                    n.gie = 1'b0;
                    n.ack = 1'b1;
                    n.ack_lvl = win_lvl;
                    n.lvl = win_lvl;
                    n.src = win_src;
                    n.pc = pc_in;
                    n.flags = flags_in;
                    n.st = pvil_pkg::ST_PUSH_PCL;
                    n.bus_req = 1'b1;
                    n.bus.op = pvil_pkg::OP_PUSH;
                    n.bus.addr = 16'h0000;
                    n.bus.wdata = pc_in[7:0];
                end
            end
            pvil_pkg::ST_PUSH_PCL: begin
                if (bus_done_in) begin
                    n.st = pvil_pkg::ST_PUSH_PCH;
                    n.bus.wdata = r.pc[15:8];
                end
            end
            pvil_pkg::ST_PUSH_PCH: begin
                if (bus_done_in) begin
                    n.st = pvil_pkg::ST_PUSH_FLG;
                    n.bus.wdata = r.flags;
                end
            end
            pvil_pkg::ST_PUSH_FLG: begin
                if (bus_done_in) begin
                    n.st = pvil_pkg::ST_FETCH_HI;
                    n.bus.op = pvil_pkg::OP_FETCH;
                    n.bus.addr = vec_addr(r.lvl, r.src);
                    n.bus.wdata = 8'h00;
                end
            end
            pvil_pkg::ST_FETCH_HI: begin
                if (bus_done_in) begin
                    n.st = pvil_pkg::ST_FETCH_LO;
                    n.vhi = bus_rdata_in;
                    n.bus.addr = vec_addr(r.lvl, r.src) | 16'h0001;
                end
            end
            pvil_pkg::ST_FETCH_LO: begin
                if (bus_done_in) begin
                    n.st = pvil_pkg::ST_IDLE;
                    n.bus_req = 1'b0;
                    n.jump = 1'b1;
                    n.jaddr = {r.vhi, bus_rdata_in};
                    if (r.lvl == 3'h0) begin
                        hw_clr[r.src] = 1'b1;
                    end
                end
            end
        endcase
        // A new event in the clearing cycle keeps its flag
        n.hwp = (r.hwp & ~hw_clr) | src_req_in[1:0];
        n.irq = |src_req_in[1:0];
        n.status = lvl_req;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            r <= '0;
            r.st <= pvil_pkg::ST_IDLE;
            r.status <= `PVIL_STATUS_RST;
            r.mask <= `PVIL_MASK_RST;
            r.prio <= `PVIL_PRIO_RST;
            r.gie <= `PVIL_GIE_RST;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata_out = r.rdata;
    assign bus_req_out = r.bus_req;
    assign bus_out = r.bus;
    assign ack_out = r.ack;
    assign ack_level_out = r.ack_lvl;
    assign irq_pulse_out = r.irq;
    assign jump_out = r.jump;
    assign jump_addr_out = r.jaddr;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence pch_s;
        r.st == pvil_pkg::ST_PUSH_PCH && bus_req_out && bus_out.op == pvil_pkg::OP_PUSH
            && bus_out.wdata == r.pc[15:8];
    endsequence

    sequence flg_s;
        r.st == pvil_pkg::ST_PUSH_FLG && bus_req_out && bus_out.wdata == r.flags;
    endsequence

    sequence fhi_s;
        r.st == pvil_pkg::ST_FETCH_HI && bus_req_out && bus_out.op == pvil_pkg::OP_FETCH
            && bus_out.addr == vec_addr(r.lvl, r.src);
    endsequence

    sequence flo_s;
        r.st == pvil_pkg::ST_FETCH_LO && bus_req_out && bus_out.op == pvil_pkg::OP_FETCH
            && bus_out.addr == (vec_addr(r.lvl, r.src) | 16'h0001);
    endsequence

    accept_at_end_a: assert property (
        (r.st == pvil_pkg::ST_PUSH_PCL && $past(r.st) == pvil_pkg::ST_IDLE) |-> $past(instr_end_in))
        else $error("interrupt accepted outside instruction end");

    ack_clears_gie_a: assert property (
        ack_out |-> !r.gie && bus_req_out && r.st == pvil_pkg::ST_PUSH_PCL && bus_out.wdata == r.pc[7:0])
        else $error("acknowledge without enable clear or low counter push");

    push_order_a: assert property (
        (r.st == pvil_pkg::ST_PUSH_PCL && bus_done_in) |=> pch_s)
        else $error("push order broken");

    flags_then_fetch_a: assert property (
        (r.st == pvil_pkg::ST_PUSH_FLG && bus_done_in) |=> fhi_s)
        else $error("vector fetch does not follow flag push");

    fetch_lo_jump_a: assert property (
        (r.st == pvil_pkg::ST_FETCH_LO && bus_done_in)
        |=> jump_out && !bus_req_out && jump_addr_out == {$past(r.vhi), $past(bus_rdata_in)})
        else $error("jump address not high then low vector byte");

    vector_even_a: assert property (
        (r.st == pvil_pkg::ST_FETCH_HI) |-> bus_out.addr[0] == 1'b0 && bus_out.addr[15:8] == 8'h00)
        else $error("vector outside even low page");

    status_mirror_a: assert property (
        $past(nrst_in) |-> r.status == $past(lvl_req))
        else $error("request status does not follow requests");

    status_reset_a: assert property (
        $past(!nrst_in) |-> r.status == 8'h00 && !r.gie)
        else $error("status or enable not cleared by reset");

    no_vector_off_a: assert property (
        (r.st == pvil_pkg::ST_IDLE && !r.gie) |=> r.st == pvil_pkg::ST_IDLE && !ack_out)
        else $error("vectored while globally disabled");

    return_sets_gie_a: assert property (
        (return_from_interrupt_in && !global_disable_instr_in && !accept
            && !(reg_wr_in && reg_addr_in == `PVIL_ADDR_MODE)) |=> r.gie)
        else $error("return did not restore global enable");

    ack_winner_a: assert property (
        accept |=> ack_out && ack_level_out == $past(win_lvl)
            && $past(r.mask[win_lvl]) && $past(lvl_req[win_lvl]))
        else $error("acknowledged level not eligible");

    hw_flag_clear_a: assert property (
        (r.st == pvil_pkg::ST_FETCH_LO && bus_done_in && r.lvl == 3'h0 && !src_req_in[r.src])
        |=> !r.hwp[$past(r.src)])
        else $error("hardware flag not cleared after service");

    hw_flag_set_a: assert property (
        src_req_in[0] |=> r.hwp[0] && irq_pulse_out)
        else $error("level 0 event not held or not signalled");

    group_order_a: assert property (
        (accept && cand[2] && cand[5] && {r.prio[7], r.prio[4], r.prio[1]} == 3'h5) |=> ack_level_out >= 3'h5)
        else $error("group C not above group B");

    push_flags_a: assert property (
        (r.st == pvil_pkg::ST_PUSH_PCH && bus_done_in) |=> flg_s)
        else $error("flag push does not follow high counter push");

    fetch_low_a: assert property (
        (r.st == pvil_pkg::ST_FETCH_HI && bus_done_in) |=> flo_s)
        else $error("low vector fetch does not follow high fetch");

    bus_hold_a: assert property (
        (r.st != pvil_pkg::ST_IDLE && !bus_done_in) |=> $stable(bus_out) && bus_req_out)
        else $error("bus request changed before completion");

    idle_no_bus_a: assert property (
        (r.st == pvil_pkg::ST_IDLE) |-> !bus_req_out)
        else $error("bus request while idle");

    ack_pulse_a: assert property (
        ack_out |=> !ack_out)
        else $error("acknowledge longer than one cycle");

    source_order_a: assert property (
        (accept && req_vec[{win_lvl, 1'b0}]) |-> !win_src)
        else $error("higher vector source chosen over lower");

    source_enable_a: assert property (
        accept |-> src_en_in[{win_lvl, win_src}])
        else $error("disabled source accepted");

    disable_gie_a: assert property (
        (global_disable_instr_in && !global_enable_instr_in && !return_from_interrupt_in) |=> !r.gie)
        else $error("disable instruction did not clear global enable");

    enable_gie_a: assert property (
        (global_enable_instr_in && !accept) |=> r.gie)
        else $error("enable instruction did not set global enable");

    status_read_a: assert property (
        (reg_rd_in && reg_addr_in == `PVIL_ADDR_STATUS) |=> reg_rdata_out == $past(r.status))
        else $error("status read returned wrong value");

    mask_write_a: assert property (
        (reg_wr_in && reg_addr_in == `PVIL_ADDR_MASK) |=> r.mask == $past(reg_wdata_in))
        else $error("mask write not taken");

    prio_write_a: assert property (
        (reg_wr_in && reg_addr_in == `PVIL_ADDR_PRIO) |=> r.prio == $past(reg_wdata_in))
        else $error("priority write not taken");

    irq_quiet_a: assert property (
        (src_req_in[1:0] == 2'h0) |=> !irq_pulse_out)
        else $error("request pulse without level 0 event");

endmodule
`default_nettype wire

// *** tb/pvil_core_model.sv ***
// Purpose: Core-side model that answers stack pushes and vector fetches
// Assumes: One bus operation outstanding at a time
// Notes: The vector byte at address a reads a ^ 5A; dly_in slows every answer
`timescale 1ns/1ps
`default_nettype none

module pvil_core_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] dly_in,
    input wire logic bus_req_in,
    input wire pvil_pkg::pvil_bus_s bus_in,
    output logic bus_done_out,
    output logic [7:0] bus_rdata_out,
    output logic [23:0] push_log_out
);
    logic [3:0] cnt_r;
    logic [7:0] data_r;

    // Fetch data is only valid with done, so show the inverse otherwise
    assign bus_rdata_out = bus_done_out ? data_r : ~data_r;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt_r <= 4'h0;
            bus_done_out <= 1'b0;
            data_r <= 8'h00;
            push_log_out <= 24'h000000;
        end else if (bus_done_out) begin
            bus_done_out <= 1'b0;
            cnt_r <= 4'h0;
        end else if (bus_req_in && cnt_r >= dly_in) begin
            bus_done_out <= 1'b1;
            data_r <= bus_in.addr[7:0] ^ 8'h5A;
            if (bus_in.op == pvil_pkg::OP_PUSH) begin
                push_log_out <= {push_log_out[15:0], bus_in.wdata};
            end
        end else if (bus_req_in) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the vectored interrupt logic
// Assumes: Core model answers the push and fetch cycles
// Notes: One task per scenario; counter 1234 and flags C3 are saved on every entry
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [15:0] src_req = 16'h0000;
    logic [15:0] src_en = 16'hFFFF;
    logic instr_end = 1'b0;
    logic global_enable_instr = 1'b0;
    logic global_disable_instr = 1'b0;
    logic return_from_interrupt = 1'b0;
    logic [3:0] dly = 4'h0;
    logic bus_req_out;
    pvil_pkg::pvil_bus_s bus_out;
    logic bus_done;
    logic [7:0] bus_rdata;
    logic ack_out;
    logic [2:0] ack_level_out;
    logic irq_pulse_out;
    logic jump_out;
    logic [15:0] jump_addr_out;
    logic [23:0] push_log;
    int failures = 0;
    int cmp_count = 0;

    always #2 clk_in = ~clk_in;

    pvil_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out), .src_req_in(src_req),
        .src_en_in(src_en), .instr_end_in(instr_end), .pc_in(16'h1234), .flags_in(8'hC3),
        .global_enable_instr_in(global_enable_instr), .global_disable_instr_in(global_disable_instr),
        .return_from_interrupt_in(return_from_interrupt), .bus_req_out(bus_req_out), .bus_out(bus_out),
        .bus_done_in(bus_done),
        .bus_rdata_in(bus_rdata), .ack_out(ack_out), .ack_level_out(ack_level_out),
        .irq_pulse_out(irq_pulse_out), .jump_out(jump_out), .jump_addr_out(jump_addr_out));

    pvil_core_model i_core (.clk_in(clk_in), .nrst_in(nrst_in), .dly_in(dly), .bus_req_in(bus_req_out),
        .bus_in(bus_out), .bus_done_out(bus_done), .bus_rdata_out(bus_rdata), .push_log_out(push_log));

    task automatic finish_test();
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(posedge clk_in);
        #1;
        check({16'h0000, reg_rdata_out}, {16'h0000, exp});
    endtask

    // Pulses {global enable, global disable, return} for one cycle
    task automatic ctl(input logic [2:0] v);
        @(posedge clk_in);
        {global_enable_instr, global_disable_instr, return_from_interrupt} <= v;
        @(posedge clk_in);
        {global_enable_instr, global_disable_instr, return_from_interrupt} <= 3'b000;
    endtask

    // Ends one instruction and returns the acknowledge seen one cycle later
    task automatic end_instr(output logic a);
        @(posedge clk_in);
        instr_end <= 1'b1;
        @(posedge clk_in);
        instr_end <= 1'b0;
        #1;
        a = ack_out;
    endtask

    task automatic no_serve();
        logic a;
        end_instr(a);
        check({23'h0, a}, 24'h0);
        check({23'h0, bus_req_out}, 24'h0);
    endtask

    task automatic serve(input logic [2:0] lvl, input logic [7:0] vec);
        logic a;
        int n;
        end_instr(a);
        check({23'h0, a}, 24'h1);
        check({21'h0, ack_level_out}, {21'h0, lvl});
        n = 0;
        while (jump_out !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (jump_out !== 1'b1) begin
            failures++;
            finish_test();
        end
        check({8'h00, jump_addr_out}, {8'h00, vec ^ 8'h5A, (vec + 8'h01) ^ 8'h5A});
        check(push_log, 24'h3412C3);
        rdc(8'hDE, 8'h00);
        ctl(3'b001);
        rdc(8'hDE, 8'h01);
    endtask

    task automatic s_regs();
        rdc(8'hDC, 8'h00);
        wr(8'hDC, 8'hFF);
        rdc(8'hDC, 8'h00);
        rdc(8'h80, 8'h00);
        rdc(8'hDE, 8'h00);
        wr(8'hFF, 8'hA5);
        rdc(8'hFF, 8'hA5);
        wr(8'hFF, 8'h00);
    endtask

    task automatic s_poll();
        wr(8'hDD, 8'hFF);
        src_req <= 16'h0840;
        rdc(8'hDC, 8'h28);
        no_serve();
        ctl(3'b100);
        ctl(3'b010);
        no_serve();
        src_req <= 16'h0000;
        rdc(8'hDC, 8'h00);
    endtask

    task automatic s_gate();
        ctl(3'b100);
        src_req <= 16'h00C0;
        wr(8'hDD, 8'hF7);
        no_serve();
        wr(8'hDD, 8'hFF);
        src_en <= 16'hFF3F;
        no_serve();
        src_en <= 16'hFFFF;
        repeat (5) @(posedge clk_in);
        check({23'h0, bus_req_out}, 24'h0);
        dly <= 4'h3;
        serve(3'd3, 8'h0C);
        src_req <= 16'h0000;
    endtask

    task automatic s_prio();
        logic [7:0] prio_t [6] = '{8'h02, 8'h82, 8'h00, 8'h00, 8'h20, 8'h60};
        logic [15:0] req_t [6] = '{16'h0414, 16'h0414, 16'h0414, 16'h5400, 16'h5400, 16'h5400};
        logic [2:0] lvl_t [6] = '{3'd2, 3'd5, 3'd1, 3'd5, 3'd6, 3'd7};
        for (int i = 0; i < 6; i++) begin
            wr(8'hFF, prio_t[i]);
            src_req <= req_t[i];
            serve(lvl_t[i], {3'b000, lvl_t[i], 2'b00});
        end
        src_req <= 16'h0000;
    endtask

    task automatic level0_event();
        @(posedge clk_in);
        src_req[0] <= 1'b1;
        @(posedge clk_in);
        src_req[0] <= 1'b0;
        #1;
        check({23'h0, irq_pulse_out}, 24'h1);
    endtask

    task automatic s_hwflag();
        dly <= 4'h0;
        wr(8'hFF, 8'h00);
        src_req <= 16'h0004;
        level0_event();
        serve(3'd0, 8'h00);
        rdc(8'hDC, 8'h02);
        wr(8'hFF, 8'h01);
        level0_event();
        serve(3'd1, 8'h04);
        src_req <= 16'h0000;
        serve(3'd0, 8'h00);
        rdc(8'hDC, 8'h00);
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        s_regs();
        s_poll();
        s_gate();
        s_prio();
        s_hwflag();
        finish_test();
    end
endmodule

`default_nettype wire
